// ---- design/crf_pkg.sv ----
// Purpose: shared constants and types of the core register file and status flags
// Assumes: single core clock, 8-bit working registers
// Notes:   status bit positions and bus offsets live here only
package crf_pkg;
  localparam int unsigned NUM_REGS  = 32;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned IO_ADDR_W = 6;

  // pointer pairs, low byte register index
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // data-space map
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_IO_LAST = 16'h005F;

  // status bit positions
  localparam int unsigned SF_I = 7;
  localparam int unsigned SF_T = 6;
  localparam int unsigned SF_H = 5;
  localparam int unsigned SF_S = 4;
  localparam int unsigned SF_V = 3;
  localparam int unsigned SF_N = 2;
  localparam int unsigned SF_Z = 1;
  localparam int unsigned SF_C = 0;
  localparam logic [7:0]  SF_RESET = 8'h00;

  // flag update mask positions {H,V,N,Z,C}
  localparam int unsigned FM_H = 4;
  localparam int unsigned FM_V = 3;
  localparam int unsigned FM_N = 2;
  localparam int unsigned FM_Z = 1;
  localparam int unsigned FM_C = 0;

  // bus register map
  localparam logic [11:0] APB_STATUS_OFS = 12'h000;
  localparam logic [11:0] APB_RF_BASE    = 12'h080;
  localparam logic [11:0] APB_RF_LAST    = 12'h0FC;

  typedef enum logic [1:0] {PTR_NONE, PTR_DISP, PTR_POSTINC, PTR_PREDEC} crf_ptr_mode_e;
  typedef logic [NUM_REGS-1:0][DATA_W-1:0] crf_file_t;
endpackage

// ---- design/crf_core_regs.sv ----
// Purpose: working register file, pointer pairs, data-space decode and status flags
// Assumes: decoder, ALU and interrupt logic run on clk_sys and drive the request ports
// Notes:   register reads are combinational; every write lands at the next rising edge
// Behaviour
// - thirty-two 8-bit working registers, each read or written in one cycle
// - two operands read, result written back, all in one cycle
// - ports: 8-bit or 16-bit read, 8-bit or 16-bit write
// - six registers form three 16-bit data-space pointers
// - the third pointer also addresses program flash tables
// - data addresses below 32 reach the working registers, not SRAM
// - 64 I/O locations reachable directly and at data addresses 20h..5Fh
// - status flags refreshed after each ALU operation
// - global interrupt enable clear means no interrupt is taken
// - taken interrupt clears global enable; return-from-interrupt sets it
// - set and clear global-interrupt instructions set or clear the enable
// - bit 6 is the copy bit for bit-store and bit-load
// - bit 5 holds half carry out of the low nibble
// - bit 4 always equals negative xor overflow
// - bit 3 flags two's complement overflow
// - bit 2 set on a negative result, cleared otherwise
// - bit 1 set on a zero result, cleared otherwise
// - bit 0 captures carry of operations that produce one
// - pointers are registers 26..31 with displacement, post-increment, pre-decrement
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module crf_core_regs #(
  parameter int unsigned DISP_W = 6
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // operand reads
  input  wire logic [4:0]            rdAddrA,
  input  wire logic [4:0]            rdAddrB,
  output logic      [7:0]            rdDataA,
  output logic      [7:0]            rdDataB,
  output logic      [15:0]           rdWordA,
  // result write
  input  wire logic                  wrEn,
  input  wire logic                  wrWide,
  input  wire logic [4:0]            wrAddr,
  input  wire logic [15:0]           wrData,
  // flag update
  input  wire logic [4:0]            flagMask,
  input  wire logic [15:0]           aluResult,
  input  wire logic                  aluWide,
  input  wire logic                  aluHalf,
  input  wire logic                  aluOvf,
  input  wire logic                  aluCarry,
  // status write from software, and copy-bit instructions
  input  wire logic                  statusWe,
  input  wire logic [7:0]            statusWdata,
  input  wire logic                  bitStoreToCopy,
  input  wire logic                  bitLoadFromCopy,
  input  wire logic [4:0]            bitReg,
  input  wire logic [2:0]            bitSel,
  // global interrupt control
  input  wire logic                  setGlobalIrqInstr,
  input  wire logic                  clearGlobalIrqInstr,
  input  wire logic                  returnFromInterrupt,
  input  wire logic                  irqPending,
  output logic                       irqAccept,
  output logic      [7:0]            coreStatusFlags,
  // pointers
  input  wire logic [1:0]            ptrSel,
  input  wire crf_pkg::crf_ptr_mode_e ptrMode,
  input  wire logic [DISP_W-1:0]     ptrDisp,
  output logic      [15:0]           ptrAddr,
  output logic      [15:0]           flashAddr,
  // data-space access
  input  wire logic [15:0]           dsAddr,
  input  wire logic                  dsRe,
  input  wire logic                  dsWe,
  input  wire logic [7:0]            dsWdata,
  output logic      [7:0]            dsRdata,
  // direct I/O access
  input  wire logic [5:0]            ioDirAddr,
  input  wire logic                  ioDirRe,
  input  wire logic                  ioDirWe,
  input  wire logic [7:0]            ioDirWdata,
  // I/O and SRAM side
  output logic      [5:0]            ioAddr,
  output logic                       ioRe,
  output logic                       ioWe,
  output logic      [7:0]            ioWdata,
  input  wire logic [7:0]            ioRdata,
  output logic      [15:0]           sramAddr,
  output logic                       sramRe,
  output logic                       sramWe,
  output logic      [7:0]            sramWdata,
  input  wire logic [7:0]            sramRdata,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr
);

  crf_pkg::crf_file_t rf_q;
  crf_pkg::crf_file_t rf_d;
  logic [7:0]         status_q;
  logic [7:0]         status_d;
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;

  function automatic logic [15:0] pairOf(input crf_pkg::crf_file_t f, input logic [4:0] lo);
    pairOf = {f[lo | 5'h01], f[lo & 5'h1E]};
  endfunction

  function automatic logic [4:0] ptrBase(input logic [1:0] sel);
    case (sel)
      2'h0:    ptrBase = crf_pkg::PTR_X_LO;
      2'h1:    ptrBase = crf_pkg::PTR_Y_LO;
      default: ptrBase = crf_pkg::PTR_Z_LO;
    endcase
  endfunction

  function automatic logic apbRfHit(input logic [11:0] a);
    apbRfHit = (a >= crf_pkg::APB_RF_BASE) && (a <= crf_pkg::APB_RF_LAST) && (a[1:0] == 2'h0);
  endfunction

  // operand and pair reads
  assign rdDataA = rf_q[rdAddrA];
  assign rdDataB = rf_q[rdAddrB];
  assign rdWordA = pairOf(rf_q, rdAddrA);

  // pointer addressing
  logic [4:0]  ptrLo;
  logic [15:0] ptrBaseVal;
  logic [15:0] ptrDispExt;
  assign ptrLo      = ptrBase(ptrSel);
  assign ptrBaseVal = pairOf(rf_q, ptrLo);
  assign ptrDispExt = {{(16-DISP_W){1'b0}}, ptrDisp};
  assign flashAddr  = pairOf(rf_q, crf_pkg::PTR_Z_LO);

  always_comb
  begin
    case (ptrMode)
      crf_pkg::PTR_DISP:   ptrAddr = ptrBaseVal + ptrDispExt;
      crf_pkg::PTR_PREDEC: ptrAddr = ptrBaseVal - 16'h0001;
      default:             ptrAddr = ptrBaseVal;
    endcase
  end

  // data-space decode
  logic dsRf;
  logic dsIo;
  logic dsSram;
  assign dsRf   = dsAddr < crf_pkg::DS_IO_BASE;
  assign dsIo   = (dsAddr >= crf_pkg::DS_IO_BASE) && (dsAddr <= crf_pkg::DS_IO_LAST);
  assign dsSram = !dsRf && !dsIo;

  // data-space I/O access wins over a direct access in the same cycle
  logic [15:0] dsIoOfs;
  assign dsIoOfs   = dsAddr - crf_pkg::DS_IO_BASE;
  assign ioAddr    = (dsIo && (dsRe || dsWe)) ? dsIoOfs[5:0] : ioDirAddr;
  assign ioRe      = (dsIo && dsRe) || (!(dsIo && dsWe) && ioDirRe);
  assign ioWe      = (dsIo && dsWe) || (!(dsIo && dsRe) && ioDirWe);
  assign ioWdata   = (dsIo && dsWe) ? dsWdata : ioDirWdata;
  assign sramAddr  = dsAddr;
  assign sramRe    = dsSram && dsRe;
  assign sramWe    = dsSram && dsWe;
  assign sramWdata = dsWdata;

  always_comb
  begin
    if (dsRf)
      dsRdata = rf_q[dsAddr[4:0]];
    else if (dsIo)
      dsRdata = ioRdata;
    else
      dsRdata = sramRdata;
  end

  // bus decode
  logic apbWr;
  logic apbStatusHit;
  logic apbHit;
  logic [4:0] apbIdx;
  assign apbStatusHit = paddr == crf_pkg::APB_STATUS_OFS;
  assign apbHit       = apbStatusHit || apbRfHit(paddr);
  assign apbIdx       = paddr[6:2];
  assign apbWr        = psel && penable && pwrite && apbHit;
  assign pready       = psel && penable;
  assign pslverr      = psel && penable && !apbHit;
  assign prdata       = prdata_q;

  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      if (apbStatusHit)
        prdata_d = {24'h000000, status_q};
      else if (apbRfHit(paddr))
        prdata_d = {24'h000000, rf_q[apbIdx]};
      else
        prdata_d = 32'h00000000;
    end
  end

  // register file next state: later writes take priority
  logic [7:0]  bitRegVal;
  logic [15:0] ptrNext;
  assign bitRegVal = rf_q[bitReg];
  assign ptrNext   = (ptrMode == crf_pkg::PTR_POSTINC) ? ptrBaseVal + 16'h0001 : ptrAddr;

  always_comb
  begin
    rf_d = rf_q;
    if (apbWr && !apbStatusHit)
      rf_d[apbIdx] = pwdata[7:0];
    if (dsWe && dsRf)
      rf_d[dsAddr[4:0]] = dsWdata;
    if ((ptrMode == crf_pkg::PTR_POSTINC) || (ptrMode == crf_pkg::PTR_PREDEC))
    begin
      rf_d[ptrLo]         = ptrNext[7:0];
      rf_d[ptrLo | 5'h01] = ptrNext[15:8];
    end
    if (wrEn)
    begin
      if (wrWide)
      begin
        rf_d[wrAddr & 5'h1E] = wrData[7:0];
        rf_d[wrAddr | 5'h01] = wrData[15:8];
      end
      else
        rf_d[wrAddr] = wrData[7:0];
    end
    if (bitLoadFromCopy)
    begin
      rf_d[bitReg]         = bitRegVal;
      rf_d[bitReg][bitSel] = status_q[crf_pkg::SF_T];
    end
  end

  // status next state
  logic resNeg;
  logic resZero;
  assign resNeg  = aluWide ? aluResult[15] : aluResult[7];
  assign resZero = aluWide ? (aluResult == 16'h0000) : (aluResult[7:0] == 8'h00);
  assign irqAccept = irqPending && status_q[crf_pkg::SF_I] && !clearGlobalIrqInstr;
  assign coreStatusFlags = status_q;

  always_comb
  begin
    status_d = status_q;
    if (apbWr && apbStatusHit)
      status_d = pwdata[7:0];
    if (statusWe)
      status_d = statusWdata;
    if (flagMask[crf_pkg::FM_H])
      status_d[crf_pkg::SF_H] = aluHalf;
    if (flagMask[crf_pkg::FM_V])
      status_d[crf_pkg::SF_V] = aluOvf;
    if (flagMask[crf_pkg::FM_N])
      status_d[crf_pkg::SF_N] = resNeg;
    if (flagMask[crf_pkg::FM_Z])
      status_d[crf_pkg::SF_Z] = resZero;
    if (flagMask[crf_pkg::FM_C])
      status_d[crf_pkg::SF_C] = aluCarry;
    status_d[crf_pkg::SF_S] = status_d[crf_pkg::SF_N] ^ status_d[crf_pkg::SF_V];
    if (bitStoreToCopy)
      status_d[crf_pkg::SF_T] = bitRegVal[bitSel];
    if (setGlobalIrqInstr || returnFromInterrupt)
      status_d[crf_pkg::SF_I] = 1'b1;
    if (clearGlobalIrqInstr || irqAccept)
      status_d[crf_pkg::SF_I] = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rf_q     <= '0;
      status_q <= crf_pkg::SF_RESET;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      rf_q     <= rf_d;
      status_q <= status_d;
      prdata_q <= prdata_d;
    end
  end

  // checks
  AST_SIGN_XOR: assert property (@(posedge clk_sys) disable iff (reset)
    status_q[crf_pkg::SF_S] == (status_q[crf_pkg::SF_N] ^ status_q[crf_pkg::SF_V]))
    else $error("sign bit differs from negative xor overflow");

  AST_NO_IRQ_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    !status_q[crf_pkg::SF_I] |-> !irqAccept)
    else $error("interrupt accepted while global enable clear");

  AST_IRQ_CLEARS_I: assert property (@(posedge clk_sys) disable iff (reset)
    irqAccept |=> !status_q[crf_pkg::SF_I])
    else $error("global enable not cleared by interrupt");

  AST_RETURN_FROM_INTERRUPT_SETS_I: assert property (@(posedge clk_sys) disable iff (reset)
    (returnFromInterrupt && !irqAccept && !clearGlobalIrqInstr) |=> status_q[crf_pkg::SF_I])
    else $error("return-from-interrupt did not set global enable");

  AST_CLI_CLEARS: assert property (@(posedge clk_sys) disable iff (reset)
    clearGlobalIrqInstr |-> (!irqAccept ##1 !status_q[crf_pkg::SF_I]))
    else $error("clear-interrupt instruction left enable set");

  AST_BIT_STORE: assert property (@(posedge clk_sys) disable iff (reset)
    bitStoreToCopy |=> status_q[crf_pkg::SF_T] == $past(bitRegVal[bitSel]))
    else $error("copy bit not loaded from register bit");

  AST_WRITE_BYTE: assert property (@(posedge clk_sys) disable iff (reset)
    (wrEn && !wrWide && !bitLoadFromCopy) |=> rf_q[$past(wrAddr)] == $past(wrData[7:0]))
    else $error("byte result not written in one cycle");

  AST_WRITE_PAIR: assert property (@(posedge clk_sys) disable iff (reset)
    (wrEn && wrWide && !bitLoadFromCopy)
      |=> pairOf(rf_q, $past(wrAddr)) == $past(wrData))
    else $error("word result not written to the pair");

  AST_ZERO_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    (flagMask[crf_pkg::FM_Z] && !bitStoreToCopy)
      |=> status_q[crf_pkg::SF_Z] == $past(resZero))
    else $error("zero flag does not follow result");

  AST_POST_INC: assert property (@(posedge clk_sys) disable iff (reset)
    (ptrMode == crf_pkg::PTR_POSTINC && !wrEn && !bitLoadFromCopy && !dsWe && !apbWr)
      |=> pairOf(rf_q, $past(ptrLo)) == $past(ptrBaseVal) + 16'h0001)
    else $error("pointer not incremented after access");

  AST_DS_REG_MAP: assert property (@(posedge clk_sys) disable iff (reset)
    (dsRe && dsAddr < crf_pkg::DS_IO_BASE) |-> (dsRdata == rf_q[dsAddr[4:0]] && !sramRe))
    else $error("low data address did not reach working register");

  AST_IO_WINDOW: assert property (@(posedge clk_sys) disable iff (reset)
    (dsRe && dsAddr >= crf_pkg::DS_IO_BASE && dsAddr <= crf_pkg::DS_IO_LAST)
      |-> (ioRe && !sramRe && dsRdata == ioRdata
           && ioAddr == 6'(dsAddr - crf_pkg::DS_IO_BASE)))
    else $error("data-space access in the I/O window did not reach I/O");

  AST_NEG_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    flagMask[crf_pkg::FM_N]
      |=> status_q[crf_pkg::SF_N] == $past(aluWide ? aluResult[15] : aluResult[7]))
    else $error("negative flag does not follow result sign");

  AST_CARRY_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    flagMask[crf_pkg::FM_C]
      |=> status_q[crf_pkg::SF_C] == $past(aluCarry))
    else $error("carry flag does not follow the ALU carry");

  AST_HALF_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    flagMask[crf_pkg::FM_H]
      |=> status_q[crf_pkg::SF_H] == $past(aluHalf))
    else $error("half carry flag does not follow the ALU");

  AST_OVF_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    flagMask[crf_pkg::FM_V]
      |=> status_q[crf_pkg::SF_V] == $past(aluOvf))
    else $error("overflow flag does not follow the ALU");

  AST_SEI_SETS: assert property (@(posedge clk_sys) disable iff (reset)
    (setGlobalIrqInstr && !clearGlobalIrqInstr && !irqAccept)
      |=> status_q[crf_pkg::SF_I])
    else $error("set-interrupt instruction left enable clear");

  AST_BIT_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
    bitLoadFromCopy
      |=> rf_q[$past(bitReg)][$past(bitSel)] == $past(status_q[crf_pkg::SF_T]))
    else $error("register bit not loaded from copy bit");

  AST_STATUS_RESET: assert property (@(posedge clk_sys)
    $fell(reset) |-> status_q == crf_pkg::SF_RESET)
    else $error("status not cleared by reset");

endmodule

// ---- testbench/crf_far_side.sv ----
// Purpose: far-side memory model feeding I/O and SRAM read data to the core
// Assumes: read data follows the address combinationally, as the core expects
// Notes:   a deselected bus shows the inverted pattern so a stale value never passes
`timescale 1ns/1ps
module crf_far_side (
  input  wire logic [5:0]  ioAddr,
  input  wire logic        ioRe,
  input  wire logic [15:0] sramAddr,
  input  wire logic        sramRe,
  output logic      [7:0]  ioRdata,
  output logic      [7:0]  sramRdata
);
  always_comb
  begin
    ioRdata   = {2'b10, ioAddr} ^ {8{~ioRe}};
    sramRdata = (sramAddr[7:0] ^ 8'h3C) ^ {8{~sramRe}};
  end
endmodule

// ---- testbench/cpu_register_file_and_status_flags_tb_top.sv ----
// Purpose: self-checking bench for the core register file and status flags
// Assumes: zero-wait APB slave, combinational reads, writes land at the next edge
// Notes:   expected values are worked out here, never read back from the design
`timescale 1ns/1ps
module cpu_register_file_and_status_flags_tb_top;
  logic        clk_sys, reset, wrEn, wrWide, aluWide, aluHalf, aluOvf, aluCarry, statusWe;
  logic        bitStoreToCopy, bitLoadFromCopy, setGlobalIrqInstr, clearGlobalIrqInstr;
  logic        returnFromInterrupt, irqPending, dsRe, dsWe, ioDirRe, ioDirWe, err;
  logic        psel, penable, pwrite, irqAccept, ioRe, ioWe, sramRe, sramWe, pready, pslverr;
  logic [4:0]  rdAddrA, rdAddrB, wrAddr, flagMask, bitReg;
  logic [15:0] wrData, aluResult, dsAddr, rdWordA, ptrAddr, flashAddr, sramAddr;
  logic [7:0]  statusWdata, dsWdata, ioDirWdata, rdDataA, rdDataB, coreStatusFlags, dsRdata;
  logic [7:0]  ioWdata, ioRdata, sramWdata, sramRdata;
  logic [5:0]  ptrDisp, ioDirAddr, ioAddr;
  logic [2:0]  bitSel;
  logic [1:0]  ptrSel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rf [32];
  int          failCount, nCompared, cycles;
  crf_pkg::crf_ptr_mode_e ptrMode;

  crf_core_regs uut (.clk_sys, .reset, .rdAddrA, .rdAddrB, .rdDataA, .rdDataB, .rdWordA,
    .wrEn, .wrWide, .wrAddr, .wrData, .flagMask, .aluResult, .aluWide, .aluHalf, .aluOvf,
    .aluCarry, .statusWe, .statusWdata, .bitStoreToCopy, .bitLoadFromCopy, .bitReg, .bitSel,
    .setGlobalIrqInstr, .clearGlobalIrqInstr, .returnFromInterrupt, .irqPending, .irqAccept,
    .coreStatusFlags, .ptrSel, .ptrMode, .ptrDisp, .ptrAddr, .flashAddr, .dsAddr, .dsRe,
    .dsWe, .dsWdata, .dsRdata, .ioDirAddr, .ioDirRe, .ioDirWe, .ioDirWdata, .ioAddr, .ioRe,
    .ioWe, .ioWdata, .ioRdata, .sramAddr, .sramRe, .sramWe, .sramWdata, .sramRdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  crf_far_side far (.ioAddr, .ioRe, .sramAddr, .sramRe, .ioRdata, .sramRdata);

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    if (failCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // request held from setup until pready is seen high at an access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      failCount++;
      stopTest();
    end
  end

  initial
  begin
    reset = 1'b1;
    ptrMode = crf_pkg::PTR_NONE;
    {wrEn, wrWide, aluWide, aluHalf, aluOvf, aluCarry, statusWe, bitStoreToCopy,
     bitLoadFromCopy, setGlobalIrqInstr, clearGlobalIrqInstr, returnFromInterrupt,
     irqPending, dsRe, dsWe, ioDirRe, ioDirWe, psel, penable, pwrite, rdAddrA, rdAddrB,
     wrAddr, flagMask, bitReg, wrData, aluResult, dsAddr, statusWdata, dsWdata, ioDirWdata,
     ptrDisp, ioDirAddr, bitSel, ptrSel, paddr, pwdata} = '0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, crf_pkg::APB_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      rf[i] = 8'(i * 7 + 3);
      @(posedge clk_sys);
      wrEn <= 1'b1; wrAddr <= 5'(i); wrData <= {8'hEE, rf[i]};
    end
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk_sys);
      wrEn <= 1'b0; rdAddrA <= 5'(i); rdAddrB <= 5'(31 - i);
      @(negedge clk_sys);
      chk(32'(rdDataA), 32'(rf[i]));
      chk(32'(rdDataB), 32'(rf[31 - i]));
    end
    // operands read and result written back in the same cycle
    @(posedge clk_sys);
    rdAddrA <= 5'd1; rdAddrB <= 5'd2; wrEn <= 1'b1; wrAddr <= 5'd1;
    wrData <= {8'h00, rf[1] + rf[2]};
    @(negedge clk_sys);
    chk(32'(rdDataA), 32'(rf[1]));
    rf[1] = rf[1] + rf[2];
    @(posedge clk_sys);
    wrWide <= 1'b1; wrAddr <= 5'h1B; wrData <= 16'h0123;
    @(negedge clk_sys);
    chk(32'(rdDataA), 32'(rf[1]));
    @(posedge clk_sys);
    wrAddr <= 5'h1E; wrData <= 16'h0456;
    @(posedge clk_sys);
    wrEn <= 1'b0; rdAddrA <= 5'h1A; ptrMode <= crf_pkg::PTR_DISP; ptrDisp <= 6'h3F;
    @(negedge clk_sys);
    chk(32'(rdWordA), 32'h0123);
    chk(32'(ptrAddr), 32'h0162);
    chk(32'(flashAddr), 32'h0456);
    @(posedge clk_sys);
    ptrMode <= crf_pkg::PTR_POSTINC;
    @(negedge clk_sys);
    chk(32'(ptrAddr), 32'h0123);
    @(posedge clk_sys);
    ptrMode <= crf_pkg::PTR_PREDEC;
    @(negedge clk_sys);
    chk(32'(ptrAddr), 32'h0123);
    @(posedge clk_sys);
    ptrMode <= crf_pkg::PTR_NONE; dsRe <= 1'b1; dsAddr <= 16'h0005;
    @(negedge clk_sys);
    chk(32'(rdWordA), 32'h0123);
    chk(32'(dsRdata), 32'(rf[5]));
    @(posedge clk_sys);
    dsAddr <= 16'h0040;
    @(negedge clk_sys);
    chk(32'({ioRe, sramRe, ioAddr, dsRdata}), 32'h0000A0A0);
    @(posedge clk_sys);
    dsAddr <= 16'h0060;
    @(negedge clk_sys);
    chk(32'({ioRe, sramRe, sramAddr, dsRdata}), 32'h1_00605C);
    @(posedge clk_sys);
    dsRe <= 1'b0; dsWe <= 1'b1; dsAddr <= 16'h001F; dsWdata <= 8'hA5;
    @(posedge clk_sys);
    dsAddr <= 16'h005F;
    @(negedge clk_sys);
    chk(32'({ioWe, ioAddr, ioWdata}), 32'h7FA5);
    @(posedge clk_sys);
    dsWe <= 1'b0; ioDirRe <= 1'b1; ioDirAddr <= 6'h15; rdAddrA <= 5'd31;
    @(negedge clk_sys);
    chk(32'({ioRe, ioAddr, rdDataA}), 32'h55A5);
    // direct I/O write beside a data-space SRAM write, Y pointer selected
    @(posedge clk_sys);
    ioDirRe <= 1'b0; ioDirWe <= 1'b1; ioDirWdata <= 8'h3C; dsWe <= 1'b1; dsAddr <= 16'h0100;
    ptrSel <= 2'h1;
    @(negedge clk_sys);
    chk(32'({ioWe, ioAddr, ioWdata}), 32'h553C);
    chk(32'({sramWe, sramAddr, sramWdata}), 32'h010100A5);
    chk(32'(ptrAddr), 32'({rf[29], rf[28]}));
    // flag updates: byte negative, zero with all carries, wide negative, carry only
    @(posedge clk_sys);
    ioDirWe <= 1'b0; dsWe <= 1'b0; flagMask <= 5'h1F; aluResult <= 16'h0080;
    @(posedge clk_sys);
    aluResult <= 16'h0000; aluHalf <= 1'b1; aluOvf <= 1'b1; aluCarry <= 1'b1;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h14);
    @(posedge clk_sys);
    aluWide <= 1'b1; aluResult <= 16'h8000; aluHalf <= 1'b0; aluCarry <= 1'b0;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h3B);
    @(posedge clk_sys);
    flagMask <= 5'h01; aluCarry <= 1'b1;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h0C);
    @(posedge clk_sys);
    flagMask <= 5'h00; bitReg <= 5'd5; bitSel <= 3'd1; bitStoreToCopy <= 1'b1;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h0D);
    @(posedge clk_sys);
    bitStoreToCopy <= 1'b0; bitLoadFromCopy <= 1'b1; bitReg <= 5'd0; bitSel <= 3'd7;
    rdAddrA <= 5'd0; irqPending <= 1'b1;
    @(negedge clk_sys);
    chk(32'({irqAccept, coreStatusFlags}), 32'h04D);
    @(posedge clk_sys);
    bitLoadFromCopy <= 1'b0; irqPending <= 1'b0; setGlobalIrqInstr <= 1'b1;
    @(negedge clk_sys);
    chk(32'(rdDataA), 32'(rf[0] | 8'h80));
    @(posedge clk_sys);
    setGlobalIrqInstr <= 1'b0; clearGlobalIrqInstr <= 1'b1; irqPending <= 1'b1;
    @(negedge clk_sys);
    chk(32'({irqAccept, coreStatusFlags}), 32'h0CD);
    @(posedge clk_sys);
    clearGlobalIrqInstr <= 1'b0;
    @(negedge clk_sys);
    chk(32'({irqAccept, coreStatusFlags}), 32'h04D);
    @(posedge clk_sys);
    irqPending <= 1'b0; returnFromInterrupt <= 1'b1;
    @(posedge clk_sys);
    returnFromInterrupt <= 1'b0; irqPending <= 1'b1;
    @(negedge clk_sys);
    chk(32'({irqAccept, coreStatusFlags}), 32'h1CD);
    @(posedge clk_sys);
    irqPending <= 1'b0;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h4D);
    // software status write port, sign bit forced to negative xor overflow
    @(posedge clk_sys);
    statusWe <= 1'b1; statusWdata <= 8'hA1;
    @(posedge clk_sys);
    statusWdata <= 8'h5D;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'hA1);
    @(posedge clk_sys);
    statusWe <= 1'b0;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h4D);
    // software saves, clobbers and restores the status over the bus
    apb(1'b0, crf_pkg::APB_STATUS_OFS, 32'h0);
    chk(rd, 32'h4D);
    apb(1'b1, crf_pkg::APB_STATUS_OFS, 32'hFFFFFF2B);
    apb(1'b0, crf_pkg::APB_STATUS_OFS, 32'h0);
    chk(rd, 32'h3B);
    apb(1'b1, crf_pkg::APB_STATUS_OFS, 32'h4D);
    apb(1'b0, crf_pkg::APB_STATUS_OFS, 32'h0);
    chk(rd, 32'h4D);
    apb(1'b1, 12'h088, 32'hFFFFFF99);
    apb(1'b0, 12'h088, 32'h0);
    chk({rd[30:0], err}, 32'h132);
    apb(1'b1, 12'h010, 32'h55);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h081, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // second reset in mid-run must clear the status again
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk(32'(coreStatusFlags), 32'h0);
    apb(1'b0, crf_pkg::APB_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    stopTest();
  end
endmodule
